//--- src/pt8_timer_pair.sv
// Paired 8-bit timer with APB register access, cascade, PPG and PWM modes
//
// The APB slave port was decided locally.
`timescale 1ns/100ps
`default_nettype none

module pt8_timer_pair (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic idle_req,
  output logic timer_output_flipflop,
  output logic low_timer_match_trigger
);

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------
  // True when the prescaler has all of its low nbits set
  function automatic logic tap_hit(input logic [8:0] presc, input int nbits);
    logic [8:0] mask;
    mask = 9'((1 << nbits) - 1);
    return (presc & mask) == mask;
  endfunction : tap_hit

  // Index decode of a word address
  function automatic logic idx_is(input logic [11:0] addr, input logic [9:0] idx);
    return addr[11:2] == idx;
  endfunction : idx_is

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  pt8_pkg::pt8_run_t run_ff;
  pt8_pkg::pt8_mode_t mode_ff;
  pt8_pkg::pt8_ffctl_t ffctl_ff;
  logic [7:0] cmp_lo_buf_ff;
  logic [7:0] cmp_lo_ff;
  logic [7:0] cmp_hi_ff;
  logic [8:0] presc_ff;
  logic tff_ff;
  logic trig_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;
  logic nxt_tff;
  logic [31:0] nxt_prdata;
  logic nxt_mapped;
  logic access_wait;
  logic wr_en;
  logic halt;
  logic presc_tick_lo;
  logic presc_tick_hi;
  logic lo_run;
  logic hi_run;
  logic lo_tick;
  logic hi_tick;
  logic lo_wrap;
  logic hi_wrap;
  logic lo_match_ev;
  logic hi_match_ev;
  logic period_ev;
  logic full_match;
  logic hw_toggle;
  logic buf_load;
  logic [7:0] pwm_mask;
  logic [7:0] lo_cnt;
  logic [7:0] hi_cnt;

  // ----------------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------------
  // One wait state: data is prepared in the first access cycle, ready in the second
  assign access_wait = psel & penable & ~pready_ff;
  assign wr_en = psel & penable & pready_ff & pwrite;

  // Read mux; compare registers are write-only and read as zero
  always_comb begin
    nxt_prdata = 32'h0000_0000;
    nxt_mapped = 1'b1;
    if (idx_is(paddr, pt8_pkg::IDX_PAIR_RUN)) begin
      nxt_prdata[7:0] = {run_ff.double_buffer_enable, 3'h0, run_ff[3:0]};
    end else if (idx_is(paddr, pt8_pkg::IDX_PAIR_MODE)) begin
      nxt_prdata[7:0] = mode_ff;
    end else if (idx_is(paddr, pt8_pkg::IDX_FF_CTRL)) begin
      nxt_prdata[7:0] = {4'h0, pt8_pkg::FF_CMD_NONE, ffctl_ff};
    end else if (idx_is(paddr, pt8_pkg::IDX_LOW_CMP) || idx_is(paddr, pt8_pkg::IDX_HIGH_CMP)) begin
      nxt_prdata = 32'h0000_0000;
    end else begin
      nxt_mapped = 1'b0;
    end
  end

  // Bus answer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= access_wait;
      pslverr_ff <= access_wait & ~nxt_mapped;
      if (access_wait && !pwrite) begin
        prdata_ff <= nxt_prdata;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_ff <= pt8_pkg::RST_PAIR_RUN;
      mode_ff <= pt8_pkg::RST_PAIR_MODE;
      ffctl_ff <= pt8_pkg::RST_FF_TOGGLE;
    end else if (wr_en) begin
      if (idx_is(paddr, pt8_pkg::IDX_PAIR_RUN)) begin
        run_ff <= {pwdata[7], 3'h0, pwdata[3:0]};
      end
      if (idx_is(paddr, pt8_pkg::IDX_PAIR_MODE)) begin
        mode_ff <= pwdata[7:0];
      end
      if (idx_is(paddr, pt8_pkg::IDX_FF_CTRL)) begin
        ffctl_ff <= pwdata[1:0];
      end
    end
  end

  // Compare registers; low compare may be double buffered against glitches mid-period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_lo_buf_ff <= pt8_pkg::RST_CMP;
      cmp_lo_ff <= pt8_pkg::RST_CMP;
      cmp_hi_ff <= pt8_pkg::RST_CMP;
    end else begin
      if (wr_en && idx_is(paddr, pt8_pkg::IDX_LOW_CMP)) begin
        cmp_lo_buf_ff <= pwdata[7:0];
      end
      if (wr_en && idx_is(paddr, pt8_pkg::IDX_HIGH_CMP)) begin
        cmp_hi_ff <= pwdata[7:0];
      end
      if (wr_en && idx_is(paddr, pt8_pkg::IDX_LOW_CMP) && !run_ff.double_buffer_enable) begin
        cmp_lo_ff <= pwdata[7:0];
      end else if (buf_load && run_ff.double_buffer_enable) begin
        cmp_lo_ff <= cmp_lo_buf_ff;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Prescaler and clock selection
  // ----------------------------------------------------------------------
  // Idle stop freezes counts without clearing them, unlike a run bit
  assign halt = idle_req & ~run_ff.idle_state_operate;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_ff <= 9'h000;
    end else if (!run_ff.prescaler_run) begin
      presc_ff <= 9'h000;
    end else if (!halt) begin
      presc_ff <= presc_ff + 9'h001;
    end
  end

  // Low timer source; code 00 has no source and never counts
  always_comb begin
    case (mode_ff.low_clock_sel)
      2'h1: presc_tick_lo = tap_hit(presc_ff, pt8_pkg::TAP_T1_BITS);
      2'h2: presc_tick_lo = tap_hit(presc_ff, pt8_pkg::TAP_T4_BITS);
      2'h3: presc_tick_lo = tap_hit(presc_ff, pt8_pkg::TAP_T16_BITS);
      default: presc_tick_lo = 1'b0;
    endcase
  end

  // High timer source; code 00 is the low timer's match trigger in two 8-bit mode, handled below
  always_comb begin
    case (mode_ff.high_clock_sel)
      2'h1: presc_tick_hi = tap_hit(presc_ff, pt8_pkg::TAP_T1_BITS);
      2'h2: presc_tick_hi = tap_hit(presc_ff, pt8_pkg::TAP_T16_BITS);
      2'h3: presc_tick_hi = tap_hit(presc_ff, pt8_pkg::TAP_T256_BITS);
      default: presc_tick_hi = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------
  // Counting and compare
  // ----------------------------------------------------------------------
  // Period mask; reserved code 00 falls back to the longest period
  always_comb begin
    case (mode_ff.pwm_cycle)
      pt8_pkg::PWM_CYC_64: pwm_mask = pt8_pkg::PWM_MASK_64;
      pt8_pkg::PWM_CYC_128: pwm_mask = pt8_pkg::PWM_MASK_128;
      default: pwm_mask = pt8_pkg::PWM_MASK_256;
    endcase
  end

  assign lo_run = run_ff.low_timer_run & run_ff.prescaler_run;
  assign hi_run = run_ff.high_timer_run & run_ff.prescaler_run;
  assign lo_tick = lo_run & ~halt & presc_tick_lo;
  assign full_match = (lo_cnt == cmp_lo_ff) && (hi_cnt == cmp_hi_ff);

  // Mode-dependent wrap points and events
  always_comb begin
    lo_wrap = 1'b0;
    hi_wrap = (hi_cnt == cmp_hi_ff);
    lo_match_ev = 1'b0;
    period_ev = 1'b0;
    hi_tick = hi_run & ~halt & presc_tick_hi;
    case (mode_ff.pair_mode)
      pt8_pkg::MODE_TWO_8BIT: begin
        lo_wrap = (lo_cnt == cmp_lo_ff);
        lo_match_ev = lo_tick & lo_wrap;
        period_ev = lo_match_ev;
        if (mode_ff.high_clock_sel == 2'h0) begin
          hi_tick = hi_run & lo_match_ev;
        end
      end
      pt8_pkg::MODE_CASCADE_16: begin
        lo_wrap = full_match;
        hi_wrap = full_match;
        hi_tick = hi_run & lo_tick & (full_match | (lo_cnt == 8'hFF));
        lo_match_ev = lo_tick & full_match;
        period_ev = lo_match_ev;
      end
      pt8_pkg::MODE_PPG_8BIT: begin
        lo_wrap = (lo_cnt == cmp_hi_ff);
        lo_match_ev = lo_tick & (lo_cnt == cmp_lo_ff);
        period_ev = lo_tick & lo_wrap;
      end
      pt8_pkg::MODE_PWM_8BIT: begin
        lo_wrap = ((lo_cnt & pwm_mask) == pwm_mask);
        lo_match_ev = lo_tick & (lo_cnt == cmp_lo_ff);
        period_ev = lo_tick & lo_wrap;
      end
      default: begin
        lo_wrap = 1'b0;
      end
    endcase
  end

  assign hi_match_ev = hi_tick & hi_wrap;
  assign buf_load = period_ev;

  pt8_counter u_low_timer (
    .pclk(pclk),
    .presetn(presetn),
    .run(lo_run),
    .inc(lo_tick),
    .wrap(lo_wrap),
    .count(lo_cnt)
  );

  pt8_counter u_high_timer (
    .pclk(pclk),
    .presetn(presetn),
    .run(hi_run),
    .inc(hi_tick),
    .wrap(hi_wrap),
    .count(hi_cnt)
  );

  // ----------------------------------------------------------------------
  // Timer output flip-flop
  // ----------------------------------------------------------------------
  // Hardware inversion source depends on mode; PPG and PWM invert at match and period
  always_comb begin
    case (mode_ff.pair_mode)
      pt8_pkg::MODE_TWO_8BIT: begin
        hw_toggle = ffctl_ff.flipflop_toggle_source ? hi_match_ev : lo_match_ev;
      end
      pt8_pkg::MODE_CASCADE_16: hw_toggle = lo_match_ev;
      default: hw_toggle = lo_match_ev ^ period_ev;
    endcase
    hw_toggle = hw_toggle & ffctl_ff.flipflop_toggle_enable;
  end

  // A software command beats a same-cycle hardware inversion
  always_comb begin
    nxt_tff = tff_ff ^ hw_toggle;
    if (wr_en && idx_is(paddr, pt8_pkg::IDX_FF_CTRL)) begin
      case (pwdata[3:2])
        pt8_pkg::FF_CMD_INVERT: nxt_tff = ~tff_ff;
        pt8_pkg::FF_CMD_SET: nxt_tff = 1'b1;
        pt8_pkg::FF_CMD_CLEAR: nxt_tff = 1'b0;
        default: nxt_tff = tff_ff ^ hw_toggle;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tff_ff <= 1'b0;
      trig_ff <= 1'b0;
    end else begin
      tff_ff <= nxt_tff;
      trig_ff <= lo_match_ev;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign timer_output_flipflop = tff_ff;
  assign low_timer_match_trigger = trig_ff;

endmodule : pt8_timer_pair

`default_nettype wire

//--- src/pt8_pkg.sv
// Package: register map, field layouts, reset values and timing taps of the paired timer
package pt8_pkg;

  // ----------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [9:0] IDX_PAIR_RUN = 10'h108;
  localparam logic [9:0] IDX_LOW_CMP = 10'h10A;
  localparam logic [9:0] IDX_HIGH_CMP = 10'h10B;
  localparam logic [9:0] IDX_PAIR_MODE = 10'h10C;
  localparam logic [9:0] IDX_FF_CTRL = 10'h10D;
  localparam int ADDR_W = 12;

  // ----------------------------------------------------------------------
  // Field encodings
  // ----------------------------------------------------------------------
  localparam logic [1:0] MODE_TWO_8BIT = 2'h0;
  localparam logic [1:0] MODE_CASCADE_16 = 2'h1;
  localparam logic [1:0] MODE_PPG_8BIT = 2'h2;
  localparam logic [1:0] MODE_PWM_8BIT = 2'h3;

  localparam logic [1:0] FF_CMD_INVERT = 2'h0;
  localparam logic [1:0] FF_CMD_SET = 2'h1;
  localparam logic [1:0] FF_CMD_CLEAR = 2'h2;
  localparam logic [1:0] FF_CMD_NONE = 2'h3;

  localparam logic [1:0] PWM_CYC_64 = 2'h1;
  localparam logic [1:0] PWM_CYC_128 = 2'h2;
  localparam logic [7:0] PWM_MASK_64 = 8'h3F;
  localparam logic [7:0] PWM_MASK_128 = 8'h7F;
  localparam logic [7:0] PWM_MASK_256 = 8'hFF;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_PAIR_RUN = 8'h00;
  localparam logic [7:0] RST_PAIR_MODE = 8'h00;
  localparam logic [1:0] RST_FF_TOGGLE = 2'h0;
  localparam logic [7:0] RST_CMP = 8'h00;

  // ----------------------------------------------------------------------
  // Prescaler: tick when the low N bits are all ones (period 2^N clocks)
  // ----------------------------------------------------------------------
  localparam int PRESC_W = 9;
  localparam int TAP_T1_BITS = 1;
  localparam int TAP_T4_BITS = 3;
  localparam int TAP_T16_BITS = 5;
  localparam int TAP_T256_BITS = 9;

  // ----------------------------------------------------------------------
  // Register layouts
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic double_buffer_enable;
    logic [2:0] unused;
    logic idle_state_operate;
    logic prescaler_run;
    logic high_timer_run;
    logic low_timer_run;
  } pt8_run_t;

  typedef struct packed {
    logic [1:0] pair_mode;
    logic [1:0] pwm_cycle;
    logic [1:0] high_clock_sel;
    logic [1:0] low_clock_sel;
  } pt8_mode_t;

  typedef struct packed {
    logic flipflop_toggle_enable;
    logic flipflop_toggle_source;
  } pt8_ffctl_t;

endpackage : pt8_pkg

//--- src/pt8_counter.sv
// Eight-bit up counter with run-clear, count strobe and synchronous wrap
`timescale 1ns/100ps
`default_nettype none

module pt8_counter (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic inc,
  input wire logic wrap,
  output logic [7:0] count
);

  logic [7:0] count_ff;

  // ----------------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------------
  // Stopped counter is held at zero so a restart always begins from a known point
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_ff <= 8'h00;
    end else if (!run) begin
      count_ff <= 8'h00;
    end else if (inc) begin
      count_ff <= wrap ? 8'h00 : count_ff + 8'h01;
    end
  end

  assign count = count_ff;

endmodule : pt8_counter

`default_nettype wire

//--- bench/pt8_timer_pair_sva.sv
// Checker: bus handshake, flip-flop commands and idle freeze of the paired timer
`timescale 1ns/100ps
`default_nettype none

module pt8_timer_pair_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic idle_req,
  input wire logic timer_output_flipflop,
  input wire logic low_timer_match_trigger
);
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic idle_op_ff;
  wire logic hit = psel && penable && pready;
  wire logic [9:0] idx = paddr[11:2];

  // Mirror of the idle-operate bit, so freeze is judged on what software set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) idle_op_ff <= 1'b0;
    else if (hit && pwrite && idx == pt8_pkg::IDX_PAIR_RUN) idle_op_ff <= pwdata[3];
  end

  sequence ff_wr(logic [1:0] cmd);
    hit && pwrite && idx == pt8_pkg::IDX_FF_CTRL && pwdata[3:2] == cmd;
  endsequence
  sequence frozen;
    (idle_req && !idle_op_ff) [*3];
  endsequence

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  one_wait_a: assert property (psel && $rose(penable) |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  ff_set_a: assert property (ff_wr(pt8_pkg::FF_CMD_SET) |=> timer_output_flipflop)
    else $error("set command ignored");
  ff_clear_a: assert property (ff_wr(pt8_pkg::FF_CMD_CLEAR) |=> !timer_output_flipflop)
    else $error("clear command ignored");
  ff_invert_a: assert property (ff_wr(pt8_pkg::FF_CMD_INVERT)
    |=> timer_output_flipflop != $past(timer_output_flipflop)) else $error("invert ignored");
  ff_read_a: assert property (hit && !pwrite && idx == pt8_pkg::IDX_FF_CTRL
    |-> prdata[3:2] == 2'h3) else $error("command field not read as 11");
  unmapped_err_a: assert property (hit && !(idx inside {[10'h108:10'h108], [10'h10A:10'h10D]})
    |-> pslverr && (pwrite || prdata == 32'h0)) else $error("unmapped access not refused");
  idle_freeze_a: assert property (frozen |-> !low_timer_match_trigger)
    else $error("match while frozen in idle");
  trig_pulse_a: assert property (low_timer_match_trigger |=> !low_timer_match_trigger)
    else $error("trigger longer than one cycle");
endmodule : pt8_timer_pair_sva

bind pt8_timer_pair pt8_timer_pair_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .idle_req(idle_req),
  .timer_output_flipflop(timer_output_flipflop),
  .low_timer_match_trigger(low_timer_match_trigger));
`default_nettype wire

//--- bench/tb_pt8_timer_pair.sv
// Testbench: registers, flip-flop commands, idle and counting modes of the paired timer
`timescale 1ns/100ps
`default_nettype none

module tb_pt8_timer_pair;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic idle_req = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, ff, trig;
  int error_cnt = 0;
  int checked = 0;
  int cyc = 0;
  localparam logic [11:0] A_RUN = {pt8_pkg::IDX_PAIR_RUN, 2'h0};
  localparam logic [11:0] A_LO = {pt8_pkg::IDX_LOW_CMP, 2'h0};
  localparam logic [11:0] A_HI = {pt8_pkg::IDX_HIGH_CMP, 2'h0};
  localparam logic [11:0] A_MODE = {pt8_pkg::IDX_PAIR_MODE, 2'h0};
  localparam logic [11:0] A_FF = {pt8_pkg::IDX_FF_CTRL, 2'h0};

  pt8_timer_pair u_pt8_timer_pair (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .idle_req(idle_req), .timer_output_flipflop(ff),
    .low_timer_match_trigger(trig));

  // ------------------------------------------------------------
  // Clock, timeout and shared tasks
  // ------------------------------------------------------------
  always #2.5 pclk = ~pclk;

  // Cut a hang short; longest mode needs about 19k cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      error_cnt++;
      results();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One APB transfer; the request stands until pready is seen at a rising edge,
  // answer taken at that edge; only the global timeout ends a hung wait
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, d, rd, err);
  endtask : wr

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 8'h00, rd, err);
    chk(rd, exp);
  endtask : rdc

  task automatic wait_ff(input logic v, output int n);
    n = 0;
    while (ff !== v && n < 20000) begin
      @(negedge pclk);
      n++;
    end
  endtask : wait_ff

  // Cycles between two rising edges of the flip-flop
  task automatic period(input int exp);
    int n, m;
    wait_ff(1'b0, n);
    wait_ff(1'b1, n);
    wait_ff(1'b0, n);
    wait_ff(1'b1, m);
    chk(n + m, exp);
  endtask : period

  // Start from a settled level so an update on the calling edge is not miscounted
  task automatic still(input int len);
    logic v;
    int c;
    c = 0;
    @(negedge pclk);
    v = ff;
    repeat (len) begin
      @(negedge pclk);
      if (ff !== v || trig !== 1'b0) c++;
      v = ff;
    end
    chk(c, 0);
  endtask : still

  // Trigger pulses seen over a window of len cycles
  task automatic pulses(input int len, input int exp);
    int c;
    c = 0;
    repeat (len) begin
      @(negedge pclk);
      if (trig === 1'b1) c++;
    end
    chk(c, exp);
  endtask : pulses

  // Low compare 2, high compare 9, clock selects from the mode argument, toggle from low timer
  task automatic cfg(input logic [7:0] mode);
    wr(A_RUN, 8'h00);
    wr(A_LO, 8'h02);
    wr(A_HI, 8'h09);
    wr(A_MODE, mode);
    wr(A_FF, 8'h0E);
    wr(A_RUN, 8'h07);
  endtask : cfg

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    logic [31:0] rd;
    logic err;
    chk(ff, 1'b0);
    rdc(A_RUN, 32'h0);
    rdc(A_MODE, 32'h0);
    rdc(A_FF, 32'h0C);
    wr(A_HI, 8'h5A);
    rdc(A_HI, 32'h0);
    apb(1'b0, 12'hFFC, 8'h00, rd, err);
    chk(err, 1'b1);
    chk(rd, 32'h0);
  endtask : t_reset

  task automatic t_mode;
    logic [7:0] v;
    for (int i = 0; i < 4; i++) begin
      v = {2'(i), 2'(3 - i), 4'hA};
      wr(A_MODE, v);
      rdc(A_MODE, {24'h0, v});
    end
    wr(A_RUN, 8'hFF);
    rdc(A_RUN, 32'h8F);
    wr(A_RUN, 8'h00);
  endtask : t_mode

  task automatic t_ff;
    logic [1:0] cmd [5] = '{pt8_pkg::FF_CMD_SET, pt8_pkg::FF_CMD_INVERT,
      pt8_pkg::FF_CMD_INVERT, pt8_pkg::FF_CMD_NONE, pt8_pkg::FF_CMD_CLEAR};
    logic exp [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    foreach (cmd[i]) begin
      wr(A_FF, {4'h0, cmd[i], 2'h0});
      @(negedge pclk);
      chk(ff, exp[i]);
    end
  endtask : t_ff

  // Idle without the operate bit freezes, with it counts; run bits off stop
  task automatic t_idle;
    cfg(8'h01);
    period(12);
    pulses(60, 10);
    @(posedge pclk);
    idle_req <= 1'b1;
    still(40);
    wr(A_RUN, 8'h0F);
    period(12);
    wr(A_RUN, 8'h0C);
    still(40);
    @(posedge pclk);
    idle_req <= 1'b0;
    wr(A_RUN, 8'h03);
    still(40);
  endtask : t_idle

  // 8-bit, PPG, PWM with cycle codes 01, 10 and 11, then the 16-bit cascade
  task automatic t_modes;
    logic [7:0] md [6] = '{8'h01, 8'h81, 8'hD1, 8'hE1, 8'hF1, 8'h41};
    int exp [6] = '{12, 20, 128, 256, 512, 9228};
    foreach (md[i]) begin
      cfg(md[i]);
      period(exp[i]);
    end
  endtask : t_modes

  // Slower taps, then the high timer as flip-flop source, fed by a tap or by low matches
  task automatic t_src;
    cfg(8'h0B);
    period(192);
    wr(A_FF, 8'h0F);
    period(640);
    cfg(8'h02);
    wr(A_FF, 8'h0F);
    period(480);
  endtask : t_src

  task automatic results;
    $display("Comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results

  // Main sequence
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_mode();
    t_ff();
    t_idle();
    t_src();
    t_modes();
    results();
  end
endmodule : tb_pt8_timer_pair
`default_nettype wire
